// File: core/ccsc_consts.vh
/*
 constants for the cpu clock and standby control block.
 assumes inclusion by bare name from the core files.
*/
`ifndef CCSC_CONSTS_VH
`define CCSC_CONSTS_VH
// register offset and reset value
`define CCSC_CTRL_ADDR 12'h0fb3
`define CCSC_CTRL_RESET 4'h0
// field positions
`define CCSC_STOP_BIT 3
`define CCSC_HALT_BIT 2
`define CCSC_SEL_HI 1
`define CCSC_SEL_LO 0
// clock select codes
`define CCSC_SEL_DIV64 2'h0
`define CCSC_SEL_DIV16 2'h1
`define CCSC_SEL_DIV8 2'h2
`define CCSC_SEL_DIV4 2'h3
// operating mode codes
`define CCSC_MODE_NORMAL 2'h0
`define CCSC_MODE_HALT 2'h1
`define CCSC_MODE_STOP 2'h2
// wait exponents, periods of fx
`define CCSC_RST_WAIT_EXP 5'h11
`define CCSC_WAIT_EXP_20 5'h14
`define CCSC_WAIT_EXP_17 5'h11
`define CCSC_WAIT_EXP_15 5'h0f
`define CCSC_WAIT_EXP_13 5'h0d
// interval timer mode codes for the stop release wait
`define CCSC_ITM_20 3'h0
`define CCSC_ITM_17 3'h3
`define CCSC_ITM_15 3'h5
`define CCSC_ITM_13 3'h7
`endif

// File: core/ccsc_divider.v
/*
 prescaler on the system oscillator enable, frozen while i_run is low.
 assumes i_fx_en pulses once per fx period; taps pulse once per tap period.
*/
`include "ccsc_consts.vh"
module ccsc_divider #(
  parameter WIDTH = 21
) (
  // clock and reset
  input wire i_clk_sys,
  input wire i_rst,
  // oscillator enable and stop
  input wire i_fx_en,
  input wire i_run,
  // counter state
  output wire [WIDTH-1:0] o_count,
  output wire [WIDTH-1:0] o_tick
);
  reg [WIDTH-1:0] count_r;
  wire [WIDTH-1:0] count_nxt;

  ////////////////////////////////////////////////////////////////
  // tick k pulses when bits k..0 roll over together
  assign count_nxt = count_r + {{(WIDTH-1){1'b0}}, 1'b1};
  assign o_tick = (i_fx_en && i_run) ? (count_r & ~count_nxt) : {WIDTH{1'b0}};
  assign o_count = count_r;

  // counter advances on each fx period while oscillating
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      count_r <= {WIDTH{1'b0}};
    end else if (i_fx_en && i_run) begin
      count_r <= count_nxt;
    end
  end
endmodule // ccsc_divider

// File: core/ccsc_clock_ctrl.v
/*
 cpu clock select and standby mode control with oscillation waits.
 assumes one cpu write port, standby instruction strobes, a release strobe,
 and an fx enable from outside; the cpu runs on o_cpu_tick pulses.
*/
// Contract
// - reset clears control, slowest clock, normal
// - control is four bits: select, mode
// - select codes map to div 64,16,8,4
// - mode codes normal, halt, stop; 11 barred
// - set mode bit means standby mode
// - release clears both mode bits
// - stop sets bit three, halt bit two
// - standby instructions ignore bank enable flag
// - switch completes within old-setting cycle bound
// - peripheral clocks divided from fx
// - one cpu clock period per machine cycle
// - reset wait build-time 2^13,15,17 fx
// - stop release wait picked by timer mode on irq, else reset wait
// - cpu held until wait counter overflows
`include "ccsc_consts.vh"
module ccsc_clock_ctrl #(
  parameter RST_WAIT_EXP = `CCSC_RST_WAIT_EXP,
  parameter DIV_WIDTH = 21
) (
  // clock and reset
  input wire i_clk_sys,
  input wire i_rst,
  // system oscillator enable, one pulse per fx period
  input wire i_fx_en,
  // register port
  input wire i_wr_en,
  input wire [11:0] i_addr,
  input wire [3:0] i_wr_data,
  output reg [3:0] o_rd_data,
  // standby instructions and release
  input wire i_stop_instr,
  input wire i_halt_instr,
  input wire i_memory_bank_enable,
  input wire i_standby_release,
  input wire i_release_by_irq,
  input wire [2:0] i_interval_timer_mode,
  // clocks and status
  output reg o_cpu_tick,
  output reg [DIV_WIDTH-1:0] o_periph_tick,
  output reg o_cpu_hold,
  output reg o_halt_mode,
  output reg o_stop_mode,
  output reg o_osc_running
);
  localparam ST_WAIT = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_HALT = 2'h2;
  localparam ST_STOP = 2'h3;

  reg [3:0] ctrl_r;
  reg [1:0] sel_act_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [4:0] wait_exp_r;
  reg [4:0] wait_exp_nxt;
  reg [1:0] sel_nxt;
  reg [3:0] ctrl_nxt;
  reg hit;
  reg [DIV_WIDTH-1:0] wait_base_r;
  reg [DIV_WIDTH-1:0] wait_base_nxt;
  wire [DIV_WIDTH-1:0] wait_mask;
  wire [DIV_WIDTH-1:0] wait_elapsed;
  wire [DIV_WIDTH-1:0] div_count;
  wire [DIV_WIDTH-1:0] div_tick;
  wire [4:0] tap_act;
  wire [4:0] tap_new;
  wire osc_run;
  wire wr_hit;

  ////////////////////////////////////////////////////////////////
  // tap index of a select code: period 2^(index+1)
  function [4:0] tap_of;
    input [1:0] sel;
    begin
      case (sel)
        `CCSC_SEL_DIV64: tap_of = 5'd5;
        `CCSC_SEL_DIV16: tap_of = 5'd3;
        `CCSC_SEL_DIV8: tap_of = 5'd2;
        default: tap_of = 5'd1;
      endcase
    end
  endfunction

  // stop release wait exponent from the timer mode
  function [4:0] itm_exp;
    input [2:0] itm;
    begin
      case (itm)
        `CCSC_ITM_17: itm_exp = `CCSC_WAIT_EXP_17;
        `CCSC_ITM_15: itm_exp = `CCSC_WAIT_EXP_15;
        `CCSC_ITM_13: itm_exp = `CCSC_WAIT_EXP_13;
        default: itm_exp = `CCSC_WAIT_EXP_20;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // oscillator halts only in stop
  assign osc_run = (state_r != ST_STOP);
  assign wr_hit = i_wr_en && (i_addr == `CCSC_CTRL_ADDR);
  assign tap_act = tap_of(sel_act_r);
  assign tap_new = tap_of(ctrl_r[`CCSC_SEL_HI:`CCSC_SEL_LO]);
  // wait counted from the release point, not from the free counter phase
  assign wait_mask = ~({DIV_WIDTH{1'b1}} << wait_exp_r);
  assign wait_elapsed = div_count - wait_base_r;

  ccsc_divider #(
    .WIDTH(DIV_WIDTH)
  ) u_div (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_fx_en(i_fx_en),
    .i_run(osc_run),
    .o_count(div_count),
    .o_tick(div_tick)
  );

  ////////////////////////////////////////////////////////////////
  // control register next value
  always @* begin
    ctrl_nxt = ctrl_r;
    if (wr_hit) begin
      ctrl_nxt = {2'b00, i_wr_data[`CCSC_SEL_HI:`CCSC_SEL_LO]};
    end
    if (state_r == ST_RUN && i_stop_instr) begin
      ctrl_nxt[`CCSC_STOP_BIT] = 1'b1;
    end else if (state_r == ST_RUN && i_halt_instr) begin
      ctrl_nxt[`CCSC_HALT_BIT] = 1'b1;
    end
    if ((state_r == ST_HALT || state_r == ST_STOP) && i_standby_release) begin
      ctrl_nxt[`CCSC_STOP_BIT:`CCSC_HALT_BIT] = `CCSC_MODE_NORMAL;
    end
  end

  // mode and wait sequencing
  always @* begin
    state_nxt = state_r;
    wait_exp_nxt = wait_exp_r;
    wait_base_nxt = wait_base_r;
    hit = 1'b0;
    case (state_r)
      ST_WAIT: begin
        // full 2^exp fx periods since the wait began
        hit = i_fx_en && ((wait_elapsed & wait_mask) == wait_mask);
        if (hit) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (ctrl_nxt[`CCSC_STOP_BIT]) begin
          state_nxt = ST_STOP;
        end else if (ctrl_nxt[`CCSC_HALT_BIT]) begin
          state_nxt = ST_HALT;
        end
      end
      ST_HALT: begin
        if (i_standby_release) begin
          state_nxt = ST_RUN;
        end
      end
      ST_STOP: begin
        if (i_standby_release) begin
          state_nxt = ST_WAIT;
          // counter is frozen in stop, so its value marks the wait start
          wait_base_nxt = div_count;
          wait_exp_nxt = i_release_by_irq ? itm_exp(i_interval_timer_mode) : RST_WAIT_EXP[4:0];
        end
      end
      default: begin
        state_nxt = ST_WAIT;
      end
    endcase
  end

  // clock select changes on the first old or new tap edge
  always @* begin
    sel_nxt = sel_act_r;
    if (div_tick[tap_act] || div_tick[tap_new]) begin
      sel_nxt = ctrl_r[`CCSC_SEL_HI:`CCSC_SEL_LO];
    end
  end

  ////////////////////////////////////////////////////////////////
  // registers
  always @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ctrl_r <= `CCSC_CTRL_RESET;
      sel_act_r <= `CCSC_SEL_DIV64;
      state_r <= ST_WAIT;
      wait_exp_r <= RST_WAIT_EXP[4:0];
      wait_base_r <= {DIV_WIDTH{1'b0}};
      o_cpu_tick <= 1'b0;
      o_periph_tick <= {DIV_WIDTH{1'b0}};
      o_cpu_hold <= 1'b1;
      o_halt_mode <= 1'b0;
      o_stop_mode <= 1'b0;
      o_osc_running <= 1'b1;
      o_rd_data <= 4'h0;
    end else begin
      ctrl_r <= ctrl_nxt;
      sel_act_r <= sel_nxt;
      state_r <= state_nxt;
      wait_exp_r <= wait_exp_nxt;
      wait_base_r <= wait_base_nxt;
      o_cpu_tick <= (state_r == ST_RUN) && div_tick[tap_act];
      o_periph_tick <= div_tick;
      o_cpu_hold <= (state_nxt != ST_RUN);
      o_halt_mode <= ctrl_nxt[`CCSC_HALT_BIT];
      o_stop_mode <= ctrl_nxt[`CCSC_STOP_BIT];
      o_osc_running <= (state_nxt != ST_STOP);
      o_rd_data <= ctrl_nxt;
    end
  end
endmodule // ccsc_clock_ctrl

// File: verif/ccsc_clock_ctrl_chk.sv
/*
 port checker for the cpu clock and standby control.
 assumes bind onto the top module; one clock domain.
*/
module ccsc_clock_ctrl_chk (
  // clock and reset
  input wire i_clk_sys,
  input wire i_rst,
  // register port
  input wire i_wr_en,
  input wire [11:0] i_addr,
  input wire [3:0] i_wr_data,
  input wire [3:0] o_rd_data,
  // standby control
  input wire i_stop_instr,
  input wire i_halt_instr,
  input wire i_standby_release,
  // status
  input wire o_cpu_tick,
  input wire o_cpu_hold,
  input wire o_halt_mode,
  input wire o_stop_mode,
  input wire o_osc_running
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////
  // register and mode relations
  a_write_loads: assert property (i_wr_en && i_addr == 12'h0fb3 && !o_cpu_hold && !i_stop_instr && !i_halt_instr
    |=> o_rd_data == {2'h0, $past(i_wr_data[1:0])}) else $error("write value wrong");
  a_mode_legal: assert property (!(o_stop_mode && o_halt_mode)) else $error("both modes set");
  a_mode_mirror: assert property (o_stop_mode == o_rd_data[3] && o_halt_mode == o_rd_data[2] && o_stop_mode == !o_osc_running)
    else $error("mode bits");
  a_stop_sets: assert property (!o_cpu_hold && i_stop_instr |=> o_stop_mode && !o_halt_mode) else $error("stop");
  a_halt_sets: assert property (!o_cpu_hold && i_halt_instr && !i_stop_instr |=> o_halt_mode && o_cpu_hold)
    else $error("halt");
  a_release_clears: assert property ((o_halt_mode || o_stop_mode) && i_standby_release
    |=> !o_halt_mode && !o_stop_mode) else $error("release");
  a_osc_stops: assert property (o_stop_mode |-> !o_osc_running && o_cpu_hold) else $error("osc in stop");
  a_release_wait: assert property (o_stop_mode && i_standby_release |=> o_cpu_hold && o_osc_running)
    else $error("stop release wait");
  a_fast_tick: assert property (o_cpu_tick && o_rd_data[1:0] == 2'h3 |=> !o_cpu_tick [*3]) else $error("tick");
  a_reset_hold: assert property ($fell(i_rst) |-> o_cpu_hold [*8]) else $error("reset wait");
endmodule // ccsc_clock_ctrl_chk
bind ccsc_clock_ctrl ccsc_clock_ctrl_chk ccsc_clock_ctrl_chk_i (.i_clk_sys, .i_rst, .i_wr_en, .i_addr, .i_wr_data,
  .o_rd_data, .i_stop_instr, .i_halt_instr, .i_standby_release, .o_cpu_tick, .o_cpu_hold, .o_halt_mode,
  .o_stop_mode, .o_osc_running);

// File: verif/ccsc_clock_ctrl_tb.sv
/*
 self-checking bench for the cpu clock and standby control.
 assumes fx equal to the system clock and a short reset wait.
*/
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; $display("Error %0t %h %h", $time, a, b); end end
module ccsc_clock_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk_sys = 0, i_rst = 1, i_wr_en = 0, i_stop_instr = 0, i_halt_instr = 0, i_standby_release = 0;
  logic i_memory_bank_enable = 0, i_release_by_irq = 0;
  logic [11:0] i_addr = 12'h0fb3;
  logic [3:0] i_wr_data = 4'h0;
  logic [2:0] i_interval_timer_mode = 3'h7;
  wire [3:0] o_rd_data;
  wire [20:0] o_periph_tick;
  wire o_cpu_tick, o_cpu_hold, o_halt_mode, o_stop_mode, o_osc_running;
  int err_count = 0, num_checks = 0, n;
  // written data, value read back
  logic [7:0] rows [5] = '{8'h00, 8'h33, 8'h11, 8'h22, 8'h33};
  // system clock
  always #5 i_clk_sys = ~i_clk_sys;
  ccsc_clock_ctrl #(.RST_WAIT_EXP(5)) ccsc_clock_ctrl_i (.i_clk_sys, .i_rst, .i_fx_en(1'b1), .i_wr_en, .i_addr,
    .i_wr_data, .o_rd_data, .i_stop_instr, .i_halt_instr, .i_memory_bank_enable, .i_standby_release,
    .i_release_by_irq, .i_interval_timer_mode, .o_cpu_tick, .o_periph_tick, .o_cpu_hold, .o_halt_mode,
    .o_stop_mode, .o_osc_running);
  ////////////////////////////////////////////////////////////
  task automatic wrap_up;
    if (err_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  function automatic int div(input logic [1:0] s);
    return s == 2'h0 ? 64 : s == 2'h1 ? 16 : s == 2'h2 ? 8 : 4;
  endfunction
  // count edges until tick, run or peripheral tap
  task automatic wait_on(input int w, input int lim, output int c);
    logic s;
    c = 0;
    do begin
      @(negedge i_clk_sys);
      c++;
      s = w == 0 ? o_cpu_tick : w == 1 ? !o_cpu_hold : o_periph_tick[1];
    end while (s !== 1'b1 && c < lim);
    if (s !== 1'b1) begin
      err_count++;
      wrap_up;
    end
  endtask
  task automatic wr(input logic [3:0] d);
    i_wr_data = d;
    i_wr_en = 1;
    @(negedge i_clk_sys);
    i_wr_en = 0;
  endtask
  task automatic pulse(input logic [2:0] p);
    {i_stop_instr, i_halt_instr, i_standby_release} = p;
    @(negedge i_clk_sys);
    {i_stop_instr, i_halt_instr, i_standby_release} = 3'h0;
    @(negedge i_clk_sys);
  endtask
  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (20) @(negedge i_clk_sys);
    `CHK({o_rd_data, o_cpu_hold, o_stop_mode, o_halt_mode}, 7'h04)
    i_rst = 0;
    wait_on(1, 100, n);
    `CHK(n >= 30 && n <= 34, 1'b1)
    wait_on(2, 8, n);
    wait_on(2, 8, n);
    `CHK(n, 4)
    foreach (rows[i]) begin
      wait_on(0, 64, n);
      wr(rows[i][7:4]);
      `CHK(o_rd_data, rows[i][3:0])
      wait_on(0, div(i == 0 ? 2'h0 : rows[i - 1][1:0]) + 1, n);
      // first period after a switch may be short
      repeat (2) wait_on(0, 64, n);
      `CHK(n, div(rows[i][1:0]))
    end
    i_addr = 12'h0fb2;
    wr(4'h0);
    `CHK(o_rd_data, 4'h3)
    i_addr = 12'h0fb3;
    i_memory_bank_enable = 1;
    pulse(3'h2);
    `CHK({o_halt_mode, o_cpu_hold, o_rd_data}, 6'h37)
    pulse(3'h1);
    `CHK(o_rd_data, 4'h3)
    wait_on(1, 100, n);
    i_memory_bank_enable = 0;
    repeat (64) @(negedge i_clk_sys);
    i_release_by_irq = 1;
    pulse(3'h6);
    `CHK({o_stop_mode, o_halt_mode, o_osc_running, o_rd_data}, 7'h4b)
    pulse(3'h1);
    `CHK({o_stop_mode, o_osc_running}, 2'h1)
    wait_on(1, 9000, n);
    `CHK(n >= 8100 && n <= 8192, 1'b1)
    // stop released without interrupt takes the reset wait
    i_release_by_irq = 0;
    pulse(3'h4);
    `CHK(o_stop_mode, 1'b1)
    pulse(3'h1);
    wait_on(1, 100, n);
    `CHK(n >= 30 && n <= 34, 1'b1)
    wrap_up;
  end
endmodule // ccsc_clock_ctrl_tb
